// ### rtl/conv_seq_pkg.sv
/*
 * Constants shared by the converter sequencer: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and an 8-bit register port.
 */
// Overview of operation
// [RULE1] A software start is taken only while the software enable bit is set.
// [RULE2] A software conversion uses the software channel select field.
// [RULE3] On channel 0 the configured current source is driven onto it.
// [RULE4] The converter powers up per request, or stays on while forced.
// [RULE5] The software end-of-conversion flag interrupts only when unmasked.
// [RULE6] Writing the start bit begins a conversion of the selected channel.
// [RULE7] A finished software conversion sets its sticky status flag.
// [RULE8] The 12-bit result splits into high bits [3:0] and low bits [7:0].
// [RULE9] Automatic conversions use the automatic channel select field.
// [RULE10] Automatic conversions repeat at the rate counter's interval.
// [RULE11] Automatic results are compared to a threshold with a polarity.
// [RULE12] Automatic conversions run only while the slot enable bit is set.
// [RULE13] A crossing with shutdown enabled switches off after the delay.
// [RULE14] Flags stay set until cleared; both result halves update together.
package conv_seq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [3:0] SW_SELECT_ADDR  = 4'h0;
    localparam logic [3:0] CTRL_ONE_ADDR   = 4'h1;
    localparam logic [3:0] INT_MASK_ADDR   = 4'h2;
    localparam logic [3:0] INT_STATUS_ADDR = 4'h3;
    localparam logic [3:0] SW_RES_HI_ADDR  = 4'h4;
    localparam logic [3:0] SW_RES_LO_ADDR  = 4'h5;
    localparam logic [3:0] AUTO_SEL_ADDR   = 4'h6;
    localparam logic [3:0] AUTO_CTRL_ADDR  = 4'h7;
    localparam logic [3:0] THR_HI_ADDR     = 4'h8;
    localparam logic [3:0] THR_LO_ADDR     = 4'h9;
    localparam logic [3:0] AUTO_RES_HI_ADDR = 4'ha;
    localparam logic [3:0] AUTO_RES_LO_ADDR = 4'hb;
    localparam logic [3:0] STATE_ADDR      = 4'hc;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int SW_EN_BIT     = 7;
    localparam int SW_START_BIT  = 4;
    localparam int FORCE_BIT     = 0;
    localparam int ISRC_LSB      = 1;
    localparam int EOC_SW_BIT    = 0;
    localparam int AUTO_THR_BIT  = 1;
    localparam int SHUT_EN_BIT   = 7;
    localparam int AUTO_EN_BIT   = 6;
    localparam int THR_POL_BIT   = 7;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and widths
    localparam logic [7:0] INT_MASK_RST = 8'h03;
    localparam int         RES_W        = 12;
    localparam int         CHAN_W       = 4;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WARMUP_NS     = 200;
    localparam int WARMUP_CYC    = (WARMUP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int AUTO_TICK_US  = 10;
    localparam int AUTO_TICK_CYC = AUTO_TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int OFF_DLY_US    = 1;
    localparam int OFF_DLY_CYC   = OFF_DLY_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_WARM, ST_CONV} seq_state_e;

endpackage : conv_seq_pkg

// ### rtl/pin_sync.sv
/*
 * Two flip-flop synchroniser for a group of pins from the analog side.
 * Assumes the group is held stable while its qualifying bit changes.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,   // System clock
    input  wire logic             nrst_i,  // Async reset, active low
    input  wire logic [WIDTH-1:0] async_i, // Pins from outside
    output logic      [WIDTH-1:0] sync_o   // Synchronised copy
);
    logic [WIDTH-1:0] meta_q;

    ////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : pin_sync

// ### rtl/conv_seq.sv
/*
 * Conversion sequencer for the general purpose converter: registers,
 * software and automatic conversion flow, threshold and shutdown, interrupt.
 * Assumes an analog core that converts after a start pulse and raises a
 * done level, with data stable, until the next start.
 */
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module conv_seq #(
    parameter int WARM_CYC  = conv_seq_pkg::WARMUP_CYC,
    parameter int TICK_CYC  = conv_seq_pkg::AUTO_TICK_CYC,
    parameter int OFF_CYC   = conv_seq_pkg::OFF_DLY_CYC
) (
    input  wire logic        SYS_CLK_I,  // 100 MHz system clock
    input  wire logic        NRST_I,     // Async reset, active low
    input  wire logic [3:0]  ADDR_I,     // Register address
    input  wire logic [7:0]  WDATA_I,    // Write data
    input  wire logic        WR_I,       // Write strobe
    input  wire logic        RD_I,       // Read strobe
    output logic      [7:0]  RDATA_O,    // Read data, cycle after strobe
    output logic             IRQ_O,      // Interrupt, active high level
    output logic             CNV_POWER_O,// Converter power on
    output logic             CNV_START_O,// Start pulse to converter
    output logic      [3:0]  CNV_CHAN_O, // Channel being converted
    output logic             ISRC_EN_O,  // Current source on channel 0
    output logic      [1:0]  ISRC_LVL_O, // Current source setting
    input  wire logic        CNV_DONE_I, // Converter done level
    input  wire logic [11:0] CNV_DATA_I, // Converter result
    output logic             SHUTDOWN_O  // Threshold shutdown request
);
    import conv_seq_pkg::*;

    logic [7:0]       sw_sel_q, ctrl_q, mask_q, stat_q, stat_d;
    logic [7:0]       asel_q, actrl_q, thr_hi_q, thr_lo_q;
    logic [RES_W-1:0] sw_res_q, auto_res_q;
    logic [RES_W:0]   pins_s;
    logic             done_s, done_prev_q, done_rise;
    logic [RES_W-1:0] data_s, thr;
    logic             sw_pend_q, auto_pend_q, cur_auto_q;
    logic             start_ok, thr_hit, rd_stat;
    logic [15:0]      warm_q;
    logic [19:0]      tick_q;
    logic [15:0]      off_q;
    logic             off_arm_q;
    seq_state_e       state_q;

    ////////////////////////////////////////////////////////////////////////
    // Synchronise the converter pins
    pin_sync #(.WIDTH(RES_W + 1)) u_sync (
        .clk_i   (SYS_CLK_I),
        .nrst_i  (NRST_I),
        .async_i ({CNV_DONE_I, CNV_DATA_I}),
        .sync_o  (pins_s)
    );
    assign done_s    = pins_s[RES_W];
    assign data_s    = pins_s[RES_W-1:0];
    assign done_rise = done_s && !done_prev_q && state_q == ST_CONV;
    assign thr       = {thr_hi_q[3:0], thr_lo_q};

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) done_prev_q <= 1'b0;
        else         done_prev_q <= done_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // Start request and threshold decode
    assign start_ok = WR_I && ADDR_I == SW_SELECT_ADDR
                      && WDATA_I[SW_START_BIT] && WDATA_I[SW_EN_BIT]; // RULE1
    // Polarity high fires above the threshold, low fires below
    assign thr_hit = done_rise && cur_auto_q
                     && (thr_hi_q[THR_POL_BIT] ? data_s > thr
                                               : data_s < thr); // RULE11
    assign rd_stat = RD_I && ADDR_I == INT_STATUS_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // Writable registers; the start bit is not stored
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sw_sel_q <= 8'h00;
            ctrl_q   <= 8'h00;
            mask_q   <= INT_MASK_RST;
            asel_q   <= 8'h00;
            actrl_q  <= 8'h00;
            thr_hi_q <= 8'h00;
            thr_lo_q <= 8'h00;
        end else if (WR_I) begin
            case (ADDR_I)
                SW_SELECT_ADDR: sw_sel_q <= WDATA_I & 8'h8f;
                CTRL_ONE_ADDR:  ctrl_q   <= WDATA_I & 8'h07;
                INT_MASK_ADDR:  mask_q   <= WDATA_I & 8'h03;
                AUTO_SEL_ADDR:  asel_q   <= WDATA_I & 8'h0f;
                AUTO_CTRL_ADDR: actrl_q  <= WDATA_I & 8'hcf;
                THR_HI_ADDR:    thr_hi_q <= WDATA_I & 8'h8f;
                THR_LO_ADDR:    thr_lo_q <= WDATA_I;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending requests
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sw_pend_q <= 1'b0;
        end else if (start_ok) begin
            sw_pend_q <= 1'b1; // RULE6
        end else if (state_q == ST_IDLE) begin
            sw_pend_q <= 1'b0;
        end
    end

    // Interval timer spans (rate + 1) ticks, the reload cycle included
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            tick_q      <= 20'h00000;
            auto_pend_q <= 1'b0;
        end else if (!actrl_q[AUTO_EN_BIT]) begin
            tick_q      <= 20'h00000; // RULE12
            auto_pend_q <= 1'b0;
        end else if (tick_q == 20'h00000) begin
            tick_q      <= 20'((actrl_q[3:0] + 1) * TICK_CYC - 1); // RULE10
            auto_pend_q <= 1'b1;
        end else begin
            tick_q <= tick_q - 20'h00001;
            if (state_q == ST_IDLE && !sw_pend_q) auto_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: software wins over automatic
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_q     <= ST_IDLE;
            cur_auto_q  <= 1'b0;
            warm_q      <= 16'h0000;
            CNV_START_O <= 1'b0;
            CNV_CHAN_O  <= 4'h0;
        end else begin
            CNV_START_O <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (sw_pend_q || auto_pend_q) begin
                        cur_auto_q <= !sw_pend_q;
                        CNV_CHAN_O <= sw_pend_q ? sw_sel_q[3:0] // RULE2
                                                : asel_q[3:0];  // RULE9
                        if (ctrl_q[FORCE_BIT]) begin
                            CNV_START_O <= 1'b1;
                            state_q     <= ST_CONV;
                        end else begin
                            warm_q  <= 16'(WARM_CYC - 1); // RULE4
                            state_q <= ST_WARM;
                        end
                    end
                end
                ST_WARM: begin
                    if (warm_q == 16'h0000) begin
                        CNV_START_O <= 1'b1;
                        state_q     <= ST_CONV;
                    end else begin
                        warm_q <= warm_q - 16'h0001;
                    end
                end
                ST_CONV: begin
                    if (done_rise) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Power follows a request unless forced on
    assign CNV_POWER_O = ctrl_q[FORCE_BIT] || state_q != ST_IDLE; // RULE4
    assign ISRC_EN_O   = CNV_POWER_O && CNV_CHAN_O == 4'h0
                         && ctrl_q[2:1] != 2'b00; // RULE3
    assign ISRC_LVL_O  = ISRC_EN_O ? ctrl_q[2:1] : 2'b00; // RULE3

    ////////////////////////////////////////////////////////////////////////
    // Results: both halves load in one edge
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sw_res_q   <= '0;
            auto_res_q <= '0;
        end else if (done_rise) begin
            if (cur_auto_q) auto_res_q <= data_s;
            else            sw_res_q   <= data_s; // RULE14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status: read clears, a new event wins
    always_comb begin
        stat_d = rd_stat ? 8'h00 : stat_q;
        if (done_rise && !cur_auto_q) stat_d[EOC_SW_BIT] = 1'b1; // RULE7
        if (thr_hit) stat_d[AUTO_THR_BIT] = 1'b1;
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) stat_q <= 8'h00;
        else         stat_q <= stat_d; // RULE14
    end

    assign IRQ_O = |(stat_q & ~mask_q); // RULE5

    ////////////////////////////////////////////////////////////////////////
    // Shutdown after the off delay unless the flag is cleared
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            off_arm_q  <= 1'b0;
            off_q      <= 16'h0000;
            SHUTDOWN_O <= 1'b0;
        end else if (thr_hit && actrl_q[SHUT_EN_BIT]) begin
            off_arm_q <= 1'b1;
            off_q     <= 16'(OFF_CYC - 1);
        end else if (off_arm_q) begin
            if (!stat_q[AUTO_THR_BIT]) begin
                off_arm_q <= 1'b0; // RULE13
            end else if (off_q == 16'h0000) begin
                off_arm_q  <= 1'b0;
                SHUTDOWN_O <= 1'b1; // RULE13
            end else begin
                off_q <= off_q - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            case (ADDR_I)
                SW_SELECT_ADDR:   RDATA_O <= sw_sel_q;
                CTRL_ONE_ADDR:    RDATA_O <= ctrl_q;
                INT_MASK_ADDR:    RDATA_O <= mask_q;
                INT_STATUS_ADDR:  RDATA_O <= stat_q;
                SW_RES_HI_ADDR:   RDATA_O <= {4'h0, sw_res_q[11:8]}; // RULE8
                SW_RES_LO_ADDR:   RDATA_O <= sw_res_q[7:0]; // RULE8
                AUTO_SEL_ADDR:    RDATA_O <= asel_q;
                AUTO_CTRL_ADDR:   RDATA_O <= actrl_q;
                THR_HI_ADDR:      RDATA_O <= thr_hi_q;
                THR_LO_ADDR:      RDATA_O <= thr_lo_q;
                AUTO_RES_HI_ADDR: RDATA_O <= {4'h0, auto_res_q[11:8]};
                AUTO_RES_LO_ADDR: RDATA_O <= auto_res_q[7:0];
                STATE_ADDR:       RDATA_O <= {4'h0, off_arm_q, cur_auto_q,
                                              CNV_POWER_O,
                                              state_q != ST_IDLE};
                default:          RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_START_ENABLED: assert property (@(posedge SYS_CLK_I) // RULE1
        disable iff (!NRST_I)
        WR_I && ADDR_I == SW_SELECT_ADDR && !WDATA_I[SW_EN_BIT]
        && !sw_pend_q |=> !sw_pend_q)
        else $error("start taken while disabled");

    AST_SW_CHANNEL: assert property (@(posedge SYS_CLK_I) // RULE2
        disable iff (!NRST_I)
        state_q == ST_IDLE && sw_pend_q |=> CNV_CHAN_O == $past(sw_sel_q[3:0]))
        else $error("wrong software channel");

    AST_ISRC_CH0: assert property (@(posedge SYS_CLK_I) // RULE3
        disable iff (!NRST_I)
        ISRC_EN_O |-> CNV_CHAN_O == 4'h0 && ISRC_LVL_O == ctrl_q[2:1])
        else $error("current source off channel 0");

    AST_WARM_START: assert property (@(posedge SYS_CLK_I) // RULE4
        disable iff (!NRST_I)
        state_q == ST_IDLE && !ctrl_q[FORCE_BIT] |-> !CNV_POWER_O
        ##0 (sw_pend_q || auto_pend_q) |=> !CNV_START_O)
        else $error("start without warm-up");

    AST_IRQ_MASKED: assert property (@(posedge SYS_CLK_I) // RULE5
        disable iff (!NRST_I)
        stat_q == 8'h01 && mask_q[EOC_SW_BIT] |-> !IRQ_O)
        else $error("masked flag reached interrupt");

    AST_START_TAKEN: assert property (@(posedge SYS_CLK_I) // RULE6
        disable iff (!NRST_I)
        start_ok && state_q == ST_IDLE && !auto_pend_q && !ctrl_q[FORCE_BIT]
        |=> ##[1:2] state_q == ST_WARM)
        else $error("start did not begin conversion");

    AST_EOC_FLAG: assert property (@(posedge SYS_CLK_I) // RULE7
        disable iff (!NRST_I)
        done_rise && !cur_auto_q |=> stat_q[EOC_SW_BIT]
        && sw_res_q == $past(data_s))
        else $error("end of conversion not recorded");

    AST_AUTO_CHANNEL: assert property (@(posedge SYS_CLK_I) // RULE9
        disable iff (!NRST_I)
        state_q == ST_IDLE && !sw_pend_q && auto_pend_q
        |=> CNV_CHAN_O == $past(asel_q[3:0]))
        else $error("wrong automatic channel");

    AST_AUTO_OFF: assert property (@(posedge SYS_CLK_I) // RULE12
        disable iff (!NRST_I)
        !actrl_q[AUTO_EN_BIT] |=> !auto_pend_q)
        else $error("automatic request while disabled");

    AST_SHUT_CANCEL: assert property (@(posedge SYS_CLK_I) // RULE13
        disable iff (!NRST_I)
        off_arm_q && !stat_q[AUTO_THR_BIT] && !SHUTDOWN_O |=> !SHUTDOWN_O)
        else $error("shutdown after flag cleared");

    COV_SW_CONV: cover property (@(posedge SYS_CLK_I)
        disable iff (!NRST_I) done_rise && !cur_auto_q);
    COV_AUTO_HIT: cover property (@(posedge SYS_CLK_I)
        disable iff (!NRST_I) thr_hit);
    COV_SHUTDOWN: cover property (@(posedge SYS_CLK_I)
        disable iff (!NRST_I) $rose(SHUTDOWN_O));
endmodule : conv_seq

// ### verif/testbench.sv
/*
 * Self-checking bench for conv_seq: register port tasks, a converter
 * responder, and directed tests of software and automatic conversions.
 * Assumes the short timing parameters below and a 100 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
    import conv_seq_pkg::*;

    logic        clk;
    logic        nrst;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        irq;
    logic        pwr;
    logic        start;
    logic [3:0]  chan;
    logic        isrc;
    logic [1:0]  lvl;
    logic        done;
    logic [11:0] data;
    logic        shut;
    logic [11:0] conv_val;
    int          mismatches;
    int          n_tests;
    int          busy_cnt;
    int          n;

    conv_seq #(.WARM_CYC(2), .TICK_CYC(4), .OFF_CYC(4)) uut (
        .SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq),
        .CNV_POWER_O(pwr), .CNV_START_O(start), .CNV_CHAN_O(chan),
        .ISRC_EN_O(isrc), .ISRC_LVL_O(lvl), .CNV_DONE_I(done),
        .CNV_DATA_I(data), .SHUTDOWN_O(shut)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Converter stand-in: result held from start, done three cycles later
    always @(posedge clk) begin
        if (start === 1'b1) begin
            done     <= 1'b0;
            data     <= conv_val;
            busy_cnt <= 3;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
            if (busy_cnt == 1) begin
                done <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison and closing
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Register port: one-cycle strobes driven just after an edge
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read and compare; data stand only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk({4'h0, rdata}, {4'h0, exp});
    endtask : rdc

    // Bounded wait for a start pulse; cnt is the cycles waited
    task automatic wait_start(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (start !== 1'b1 && cnt < 100);
        chk(12'(start), 12'h1);
    endtask : wait_start

    task automatic wait_irq();
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (irq !== 1'b1 && k < 60);
        chk(12'(irq), 12'h1);
    endtask : wait_irq

    task automatic count_starts(input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc) begin
            @(negedge clk);
            if (start !== 1'b0) cnt++;
        end
    endtask : count_starts

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        #50000;
        mismatches++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end

    // Test sequence
    initial begin
        nrst = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        done = 1'b0;
        data = 12'h000;
        conv_val = 12'h000;
        busy_cnt = 0;
        mismatches = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, unmapped place
        rdc(INT_MASK_ADDR, INT_MASK_RST);
        rdc(INT_STATUS_ADDR, 8'h00);
        wr_reg(4'hd, 8'hff);
        rdc(4'hd, 8'h00);
        chk(12'(irq), 12'h0);
        $display("reset test done");
        // Start without enable is ignored
        wr_reg(SW_SELECT_ADDR, 8'h15);
        count_starts(20, n);
        chk(12'(n), 12'h0);
        chk(12'(pwr), 12'h0);
        $display("enable test done");
        // Unmasked software conversion on channel 5
        wr_reg(INT_MASK_ADDR, 8'h02);
        conv_val = 12'habc;
        wr_reg(SW_SELECT_ADDR, 8'h95);
        wait_start(n);
        chk(12'(chan), 12'h5);
        chk(12'(pwr), 12'h1);
        chk(12'(isrc), 12'h0);
        wait_irq();
        rdc(SW_RES_HI_ADDR, 8'h0a);
        rdc(SW_RES_LO_ADDR, 8'hbc);
        rdc(INT_STATUS_ADDR, 8'h01);
        @(negedge clk);
        chk(12'(irq), 12'h0);
        rdc(INT_STATUS_ADDR, 8'h00);
        $display("software conversion test done");
        // Masked conversion on channel 0 with current source
        wr_reg(INT_MASK_ADDR, 8'h03);
        wr_reg(CTRL_ONE_ADDR, 8'h04);
        conv_val = 12'h123;
        wr_reg(SW_SELECT_ADDR, 8'h90);
        wait_start(n);
        chk(12'(chan), 12'h0);
        chk(12'(isrc), 12'h1);
        chk(12'(lvl), 12'h2);
        repeat (15) @(negedge clk);
        chk(12'(irq), 12'h0);
        rdc(INT_STATUS_ADDR, 8'h01);
        rdc(SW_RES_LO_ADDR, 8'h23);
        chk(12'(pwr), 12'h0);
        $display("channel zero test done");
        // Forced power while idle, then a conversion with no warm-up
        wr_reg(CTRL_ONE_ADDR, 8'h01);
        @(negedge clk);
        chk(12'(pwr), 12'h1);
        wr_reg(SW_SELECT_ADDR, 8'h92);
        wait_start(n);
        chk(12'(n), 12'h2);
        chk(12'(chan), 12'h2);
        repeat (15) @(negedge clk);
        rdc(INT_STATUS_ADDR, 8'h01);
        wr_reg(CTRL_ONE_ADDR, 8'h00);
        @(negedge clk);
        chk(12'(pwr), 12'h0);
        $display("force test done");
        // Automatic conversions on channel 3, rate 7, above 0x100
        wr_reg(INT_MASK_ADDR, 8'h01);
        wr_reg(AUTO_SEL_ADDR, 8'h03);
        wr_reg(THR_HI_ADDR, 8'h81);
        wr_reg(THR_LO_ADDR, 8'h00);
        conv_val = 12'h200;
        wr_reg(AUTO_CTRL_ADDR, 8'h47);
        wait_start(n);
        chk(12'(chan), 12'h3);
        wait_start(n);
        chk(12'(n), 12'd32);
        wait_irq();
        rdc(AUTO_RES_HI_ADDR, 8'h02);
        rdc(AUTO_RES_LO_ADDR, 8'h00);
        rdc(INT_STATUS_ADDR, 8'h02);
        conv_val = 12'h050;
        wait_start(n);
        rdc(INT_STATUS_ADDR, 8'h02);
        repeat (15) @(negedge clk);
        chk(12'(irq), 12'h0);
        wr_reg(THR_HI_ADDR, 8'h01);
        wait_irq();
        wr_reg(AUTO_CTRL_ADDR, 8'h07);
        rdc(INT_STATUS_ADDR, 8'h02);
        count_starts(80, n);
        chk(12'(n), 12'h0);
        $display("automatic test done");
        // Shutdown: cancelled by a prompt clear, then taken
        wr_reg(AUTO_CTRL_ADDR, 8'hc7);
        wait_irq();
        rdc(INT_STATUS_ADDR, 8'h02);
        repeat (10) @(negedge clk);
        chk(12'(shut), 12'h0);
        wait_irq();
        repeat (8) @(negedge clk);
        chk(12'(shut), 12'h1);
        $display("shutdown test done");
        stop_test();
    end

endmodule : testbench
